/* verif/event_net_model.sv */
module event_net_model (
	input  wire logic            sys_clk_in,
	input  wire logic            req_a_in,
	input  wire logic            req_b_in,
	output pwm_fault_pkg::fault_t fault_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import pwm_fault_pkg::*;

	// ==========================================================
	// Event routing
	// Requests are re-timed to the system clock, as a routed
	// channel would be, so each one lands one clock after asking
	always_ff @(posedge sys_clk_in) begin
		fault_out.a <= req_a_in;
		fault_out.b <= req_b_in;
	end
endmodule : event_net_model

/* verif/pwm_fault_dither_tb_top.sv */
module pwm_fault_dither_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pwm_fault_pkg::*;

	// ==========================================================
	// Stimulus and observation
	logic        sys_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = '0;
	logic [1:0]  htrans  = '0;
	logic        hwrite  = 1'b0;
	logic [2:0]  hsize   = 3'h2;
	logic [31:0] hwdata  = '0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        req_a   = 1'b0;
	logic        req_b   = 1'b0;
	fault_t      fault;
	logic        out_a;
	logic        out_b;
	int          n_mismatch = 0;
	int          checked    = 0;
	logic [31:0] seed       = 32'h311b;
	logic [31:0] rd;
	int          per;
	int          hi_a;
	int          hi_b;
	logic [7:0]  ofs [10] = '{OFS_CTRL, OFS_DITHER, OFS_DINC, OFS_LEN0,
		8'h10, 8'h14, 8'h18, OFS_CMD, OFS_STATUS, 8'h40};
	logic [31:0] rstv [10] = '{0, 0, 0, {20'h0, LEN_RST},
		{20'h0, LEN_RST}, {20'h0, LEN_RST}, {20'h0, LEN_RST}, 0, 1, 0};
	logic [31:0] msk [10] = '{32'h7ff, 32'h3, 32'hffff, 32'hfff,
		32'hfff, 32'hfff, 32'hfff, 0, 0, 0};
	logic [3:0]  fmode [7] = '{FR_NONE, FR_OFF, FR_BLOCK, FR_LEVEL, 4'hb,
		FR_DEAD, FR_EDGE};
	int          fhold [7] = '{5, 5, 1, 1, 5, 5, 1};
	logic        fexp [7]  = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	int          fper [7]  = '{28, 28, 28, 28, 28, 26, 26};
	logic [3:0]  wmode [4] = '{FR_WAIT, FR_OTHER, FR_WAITB, FR_RUN};
	logic [5:0]  wafter [4] = '{6'h04, 6'h01, 6'h04, 6'h00};

	always #10 sys_clk = ~sys_clk;

	pwm_fault_dither uut (
		.sys_clk_in    (sys_clk),
		.rst_b_in      (rst_b),
		.hsel_in       (hsel),
		.haddr_in      (haddr),
		.htrans_in     (htrans),
		.hwrite_in     (hwrite),
		.hsize_in      (hsize),
		.hwdata_in     (hwdata),
		.hready_in     (hreadyout),
		.hrdata_out    (hrdata),
		.hreadyout_out (hreadyout),
		.hresp_out     (hresp),
		.fault_in      (fault),
		.waveform_out_a(out_a),
		.waveform_out_b(out_b)
	);

	event_net_model event_src (
		.sys_clk_in(sys_clk),
		.req_a_in  (req_a),
		.req_b_in  (req_b),
		.fault_out (fault)
	);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Clocks added to one cycle by one carry
	function automatic int dith_add(input int wg, input int sel);
		if (wg == 3) return 0;
		if (wg == 0) return (sel < 2) ? 1 : 0;
		if (wg == 2) return (sel % 2) ? 2 : 1;
		return (sel == 0) ? 1 : (sel == 1) ? 2 : 0;
	endfunction : dith_add

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic give_up();
		n_mismatch++;
		$display("wait limit reached at %0t", $time);
		tally_and_finish();
	endtask : give_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Entered just after a rising edge; address then data phase
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int i;
		i = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		for (int ph = 0; ph < 2; ph++) begin
			do begin
				@(posedge sys_clk);
				i++;
			end while (hreadyout !== 1'b1 && i < 40);
			if (i >= 40) give_up();
			if (ph == 0) begin
				htrans <= 2'h0;
				hwdata <= wd;
			end
		end
		rd = hrdata;
	endtask : bus

	task automatic status_is(input logic [7:0] e);
		bus(1'b0, OFS_STATUS, '0);
		check({24'h0, rd[7:0]}, {24'h0, e});
	endtask : status_is

	task automatic wait_a(input logic lvl);
		int i;
		i = 0;
		while (out_a !== lvl) begin
			@(posedge sys_clk);
			i++;
			if (i > 3000) give_up();
		end
	endtask : wait_a

	task automatic wait_rise();
		wait_a(1'b0);
		wait_a(1'b1);
	endtask : wait_rise

	// Called at a rise of output A; spans n whole cycles
	task automatic count(input int n);
		int   k;
		logic prev;
		k = 0;
		prev = 1'b1;
		per = 0;
		hi_a = 0;
		hi_b = 0;
		while (k < n) begin
			hi_a += (out_a === 1'b1);
			hi_b += (out_b === 1'b1);
			@(posedge sys_clk);
			per++;
			if (out_a === 1'b1 && prev === 1'b0) k++;
			prev = out_a;
			if (per > 6000) give_up();
		end
	endtask : count

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] v;
		int          sum;
		int          lens [4];
		int          bper;
		int          bhb;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		for (int j = 0; j < 10; j++) begin
			bus(1'b0, ofs[j], '0);
			check(rd, rstv[j]);
			check({31'h0, hresp}, 32'h0);
		end
		for (int j = 0; j < 10; j++) begin
			v = xs();
			if (j != 8) begin
				bus(1'b1, ofs[j], v);
				bus(1'b0, ofs[j], '0);
				check(rd, v & msk[j]);
			end
		end
		$display("test registers done");
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_DINC, 32'h0);
		sum = 0;
		for (int j = 0; j < 4; j++) begin
			lens[j] = 2 + int'(xs() % 8);
			sum += lens[j];
			bus(1'b1, OFS_LEN0 + 8'(4 * j), 32'(lens[j]));
		end
		bus(1'b1, OFS_CTRL, 32'h1);
		wait_rise();
		// Two cycles first, so dither left by the register test drains
		count(2);
		count(2);
		check(32'(per), 32'(2 * sum));
		check(32'(hi_a), 32'(2 * lens[1]));
		check(32'(hi_b), 32'(2 * lens[3]));
		$display("test plain cycle done");
		for (int j = 0; j < 4; j++) begin
			bus(1'b1, OFS_LEN0 + 8'(4 * j), (j % 2) ? 32'h8 : 32'h6);
		end
		for (int j = 0; j < 7; j++) begin
			bus(1'b1, OFS_CTRL, 32'h1 | 32'(fmode[j]) << 3);
			wait_rise();
			fork
				count(1);
				begin
					repeat (2) @(posedge sys_clk);
					req_a <= 1'b1;
					repeat (fhold[j]) @(posedge sys_clk);
					req_a <= 1'b0;
				end
				begin
					repeat (6) @(posedge sys_clk);
					check({31'h0, out_a}, {31'h0, fexp[j]});
				end
			join
			check(32'(per), 32'(fper[j]));
		end
		$display("test output kill done");
		for (int j = 0; j < 4; j++) begin
			bus(1'b1, OFS_CTRL, 32'h1 | 32'(wmode[j]) << 3);
			wait_rise();
			repeat (2) @(posedge sys_clk);
			req_a <= 1'b1;
			repeat (30) @(posedge sys_clk);
			bus(1'b0, OFS_STATUS, '0);
			check({30'h0, rd[6], rd[4]}, {31'h0, j < 3});
			req_a <= 1'b0;
			repeat (4) @(posedge sys_clk);
			if (j < 3) status_is({2'b00, wafter[j]});
			wait_rise();
		end
		$display("test wait modes done");
		bus(1'b1, OFS_CTRL, 32'h1 | 32'(FR_HALT) << 3);
		wait_rise();
		req_b <= 1'b1;
		repeat (5) @(posedge sys_clk);
		status_is(8'h20);
		req_b <= 1'b0;
		repeat (10) @(posedge sys_clk);
		status_is(8'h20);
		// Software restart while the event is still high
		req_a <= 1'b1;
		bus(1'b1, OFS_CMD, 32'h1 << CMD_RESTART);
		repeat (5) @(posedge sys_clk);
		status_is(8'h20);
		req_a <= 1'b0;
		repeat (3) @(posedge sys_clk);
		bus(1'b1, OFS_CMD, 32'h1 << CMD_RESTART);
		repeat (3) @(posedge sys_clk);
		status_is(8'h01);
		$display("test halt done");
		// Half-step increment: exactly two carries in any four cycles
		for (int w = 0; w < 4; w++) begin
			for (int s = 0; s < 4; s++) begin
				bus(1'b1, OFS_CTRL, 32'h1 | 32'(w) << 1);
				bus(1'b1, OFS_DITHER, 32'(s));
				bus(1'b1, OFS_DINC, 32'h0);
				wait_rise();
				count(2);
				count(4);
				bper = per;
				bhb = hi_b;
				bus(1'b1, OFS_DINC, 32'h8000);
				wait_rise();
				count(2);
				count(4);
				check(32'(per - bper), 32'(2 * dith_add(w, s)));
				if (w < 2 && s >= 2) begin
					check(32'(bhb - hi_b), 32'd2);
				end
			end
		end
		$display("test dither done");
		tally_and_finish();
	end
endmodule : pwm_fault_dither_tb_top

/* verilog/pwm_dither_acc.sv */
module pwm_dither_acc #(
	parameter int DIT_W = pwm_fault_pkg::DITHER_W_DEF
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             step_in,
	input  wire logic [DIT_W-1:0] inc_in,
	output logic                  carry_out
);
	import pwm_fault_pkg::*;

	logic [DIT_W-1:0] acc;
	logic [DIT_W:0]   next_sum;

	// ==========================================================
	// Fractional error accumulator, carry is the extra-cycle request
	assign next_sum = {1'b0, acc} + {1'b0, inc_in};

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			acc <= '0;
		end else if (step_in) begin
			acc <= next_sum[DIT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			carry_out <= 1'b0;
		end else begin
			carry_out <= step_in && next_sum[DIT_W];
		end
	end
endmodule : pwm_dither_acc

/* verilog/pwm_fault_dither.sv */
// Function
// - Mode 1: cut output, wait, resume other dead-time
// - Mode 2: run other cycle, wait, resume own
// - Mode 3: keep running other cycle while active
// - Mode 6: both outputs off, wait, other dead-time
// - Mode 7: stop both until software restart
// - Mode 8: edge ends on-time, other dead-time
// - Mode 9: edge blanks rest of on-time
// - Mode 10: output off from active to end of that on-time
// - Accumulate fraction per cycle, carry adds cycle
// - Placement: on B, on AB, dead B, dead AB
// - Dual slope never adds dither cycles
// - One ramp: on-time adds one, dead none
// - Two and four ramp addition counts
// - Zero-add placements shorten following state
// - One ramp dead B: longer dead, shorter on
// - Mode 4: both outputs off, counter untouched
// - Mode 5: alternate dead-times while active
// - Restart with input active halts again
module pwm_fault_dither #(
	parameter int DIT_W = pwm_fault_pkg::DITHER_W_DEF
) (
	input  wire logic                  sys_clk_in,
	input  wire logic                  rst_b_in,
	input  wire logic                  hsel_in,
	input  wire logic [31:0]           haddr_in,
	input  wire logic [1:0]            htrans_in,
	input  wire logic                  hwrite_in,
	input  wire logic [2:0]            hsize_in,
	input  wire logic [31:0]           hwdata_in,
	input  wire logic                  hready_in,
	output logic [31:0]                hrdata_out,
	output logic                       hreadyout_out,
	output logic                       hresp_out,
	input  wire pwm_fault_pkg::fault_t fault_in,
	output logic                       waveform_out_a,
	output logic                       waveform_out_b
);
	import pwm_fault_pkg::*;

	ctrl_t            ctrl;
	logic [1:0]       dither_placement_select;
	logic [DIT_W-1:0] dinc;
	logic [LEN_W-1:0] len_q [0:3];
	logic             wr_pend;
	logic [5:0]       wr_word;
	logic             restart_req;
	logic [3:0]       div;
	logic             tick;
	phase_t           state;
	phase_t           next_state;
	phase_t           resume;
	phase_t           next_resume;
	logic             arm2;
	logic             next_arm2;
	logic [LEN_W:0]   cnt;
	logic             ph_end;
	logic             load;
	logic             prev_a;
	logic             prev_b;
	logic             rise_a;
	logic             rise_b;
	logic             any_f;
	logic             blk_a;
	logic             blk_b;
	logic             kill_a;
	logic             kill_b;
	logic             carry;
	logic             pend;
	logic             cyc_hit;
	logic             step;
	logic             hit_now;
	logic [3:0]       fsel;
	logic [1:0]       wg;

	assign fsel = ctrl.fsel;
	assign wg   = ctrl.waveform_generation_select;

	// ==========================================================
	// AHB-Lite slave, zero wait states
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_pend <= 1'b0;
			wr_word <= '0;
		end else if (hready_in) begin
			wr_pend <= hsel_in && htrans_in[1] && hwrite_in;
			wr_word <= haddr_in[7:2];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl <= '0;
			dither_placement_select <= DSEL_RST;
			dinc <= '0;
		end else if (wr_pend) begin
			if (wr_word == OFS_CTRL[7:2])
				ctrl <= hwdata_in[CTRL_W-1:0];
			if (wr_word == OFS_DITHER[7:2])
				dither_placement_select <= hwdata_in[1:0];
			if (wr_word == OFS_DINC[7:2])
				dinc <= hwdata_in[DIT_W-1:0];
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_len
		always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				len_q[i] <= LEN_RST;
			end else if (wr_pend &&
				wr_word == OFS_LEN0[7:2] + 6'(i)) begin
				len_q[i] <= hwdata_in[LEN_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hrdata_out <= '0;
		end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
			hrdata_out <= '0;
			case (haddr_in[7:0])
				OFS_CTRL:   hrdata_out[CTRL_W-1:0] <= ctrl;
				OFS_DITHER: hrdata_out[1:0] <= dither_placement_select;
				OFS_DINC:   hrdata_out[DIT_W-1:0] <= dinc;
				OFS_STATUS: begin
					hrdata_out[5:0] <= state;
					hrdata_out[ST_OUT_A] <= waveform_out_a;
					hrdata_out[ST_OUT_B] <= waveform_out_b;
					hrdata_out[ST_PEND] <= pend;
				end
				default: begin
					if (haddr_in[7:2] >= OFS_LEN0[7:2] &&
						haddr_in[7:2] < OFS_CMD[7:2])
						hrdata_out[LEN_W-1:0] <=
							len_q[2'(haddr_in[7:2] - OFS_LEN0[7:2])];
				end
			endcase
		end
	end

	// Restart is held until the next counter tick so it is not lost
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			restart_req <= 1'b0;
		end else if (wr_pend && wr_word == OFS_CMD[7:2] &&
			hwdata_in[CMD_RESTART]) begin
			restart_req <= 1'b1;
		end else if (tick) begin
			restart_req <= 1'b0;
		end
	end

	// ==========================================================
	// Counter clock enable
	assign tick = ctrl.enable && (div == ctrl.presc);

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div <= '0;
		end else begin
			div <= (tick || !ctrl.enable) ? 4'h0 : div + 4'h1;
		end
	end

	// ==========================================================
	// Dither placement and phase lengths
	function automatic logic [1:0] pidx(input phase_t p);
		case (p)
			ST_OTA:  pidx = 2'h1;
			ST_DTB:  pidx = 2'h2;
			ST_OTB:  pidx = 2'h3;
			default: pidx = 2'h0;
		endcase
	endfunction : pidx

	function automatic logic ext_of(input phase_t p);
		logic c;
		c = 1'b0;
		case (p)
			ST_OTB: c = dither_placement_select inside {DS_ON_B, DS_ON_AB};
			ST_OTA: c = dither_placement_select == DS_ON_AB && wg != WG_ONE;
			ST_DTB: c = dither_placement_select inside {DS_DT_B, DS_DT_AB};
			ST_DTA: c = dither_placement_select == DS_DT_AB && wg != WG_ONE;
			default: c = 1'b0;
		endcase
		ext_of = hit_now && wg != WG_DUAL && c;
	endfunction : ext_of

	// One and two ramp cycles are fixed by the clear compare, so a
	// longer dead-time is paid back by the on-time behind it
	function automatic logic shr_of(input phase_t p);
		shr_of = (wg == WG_ONE || wg == WG_TWO) &&
			((p == ST_OTB && ext_of(ST_DTB)) ||
			 (p == ST_OTA && ext_of(ST_DTA)));
	endfunction : shr_of

	function automatic logic [LEN_W:0] load_val(input phase_t p);
		logic [LEN_W:0] v;
		v = {1'b0, len_q[pidx(p)]} + (LEN_W+1)'(ext_of(p));
		if (shr_of(p) && v != '0)
			v = v - 1'b1;
		load_val = (v == '0) ? '0 : v - 1'b1;
	endfunction : load_val

	// ==========================================================
	// Fault response sequencing
	assign any_f  = fault_in.a || fault_in.b;
	assign rise_a = fault_in.a && !prev_a;
	assign rise_b = fault_in.b && !prev_b;
	assign ph_end = (cnt == '0);

	always_comb begin
		next_resume = resume;
		next_arm2   = arm2;
		next_state  = state;
		if (ph_end) begin
			case (state)
				ST_DTA:  next_state = ST_OTA;
				ST_OTA:  next_state = ST_DTB;
				ST_DTB:  next_state = ST_OTB;
				ST_OTB:  next_state = ST_DTA;
				default: next_state = state;
			endcase
		end
		case (fsel)
			FR_WAIT: begin
				if (fault_in.a && state inside {ST_DTA, ST_OTA}) begin
					next_state = ST_WAIT;
					next_resume = ST_DTB;
				end else if (fault_in.b && state inside {ST_DTB, ST_OTB}) begin
					next_state = ST_WAIT;
					next_resume = ST_DTA;
				end
			end
			FR_OTHER: begin
				if (arm2 && ph_end &&
					state == (resume == ST_DTA ? ST_OTB : ST_OTA)) begin
					next_state = any_f ? ST_WAIT : resume;
					next_arm2 = 1'b0;
				end else if (!arm2 && fault_in.a &&
					state inside {ST_DTA, ST_OTA}) begin
					next_state = ST_DTB;
					next_arm2 = 1'b1;
					next_resume = ST_DTA;
				end else if (!arm2 && fault_in.b &&
					state inside {ST_DTB, ST_OTB}) begin
					next_state = ST_DTA;
					next_arm2 = 1'b1;
					next_resume = ST_DTB;
				end
			end
			FR_RUN: begin
				if (fault_in.a && (state inside {ST_DTA, ST_OTA} ||
					(state == ST_OTB && ph_end)))
					next_state = ST_DTB;
				else if (fault_in.b && (state inside {ST_DTB, ST_OTB} ||
					(state == ST_OTA && ph_end)))
					next_state = ST_DTA;
			end
			FR_DEAD: begin
				if (any_f && (state == ST_OTA || (state == ST_DTA && ph_end)))
					next_state = ST_DTB;
				else if (any_f &&
					(state == ST_OTB || (state == ST_DTB && ph_end)))
					next_state = ST_DTA;
			end
			FR_WAITB: begin
				if (any_f && (state == ST_OTA || (state == ST_DTA && ph_end))) begin
					next_state = ST_WAIT;
					next_resume = ST_DTB;
				end else if (any_f &&
					(state == ST_OTB || (state == ST_DTB && ph_end))) begin
					next_state = ST_WAIT;
					next_resume = ST_DTA;
				end
			end
			FR_HALT: begin
				if (any_f)
					next_state = ST_HALT;
			end
			FR_EDGE: begin
				if (rise_a && state == ST_OTA)
					next_state = ST_DTB;
				else if (rise_b && state == ST_OTB)
					next_state = ST_DTA;
			end
			default: next_state = next_state;
		endcase
		if (state == ST_WAIT)
			next_state = (any_f && fsel inside {FR_WAIT, FR_OTHER,
				FR_WAITB}) ? ST_WAIT : resume;
		if (state == ST_HALT)
			next_state = ((restart_req || fsel != FR_HALT) && !any_f) ?
				ST_DTA : ST_HALT;
	end

	assign load = ph_end || next_state != state;
	assign step = tick && load && next_state == ST_DTA && state != ST_DTA;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state  <= ST_DTA;
			resume <= ST_DTA;
			arm2   <= 1'b0;
			cnt    <= '0;
		end else if (!ctrl.enable) begin
			state  <= ST_DTA;
			arm2   <= 1'b0;
			cnt    <= load_val(ST_DTA);
		end else if (tick) begin
			state  <= next_state;
			resume <= next_resume;
			arm2   <= next_arm2;
			cnt    <= load ? load_val(next_state) : cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else if (tick) begin
			prev_a <= fault_in.a;
			prev_b <= fault_in.b;
		end
	end

	// ==========================================================
	// Dither request, taken once per cycle at the dead-time A start
	// The dead-time A load at a step already sees the new request, so
	// it and the on-time A that pays it back belong to one cycle
	assign hit_now = step ? pend : cyc_hit;
	pwm_dither_acc #(
		.DIT_W(DIT_W)
	) u_acc (
		.sys_clk_in(sys_clk_in),
		.rst_b_in  (rst_b_in),
		.step_in   (step),
		.inc_in    (dinc),
		.carry_out (carry)
	);

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend    <= 1'b0;
			cyc_hit <= 1'b0;
		end else begin
			pend <= carry || (pend && !step);
			if (step)
				cyc_hit <= pend;
		end
	end

	// ==========================================================
	// Output blanking
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			blk_a <= 1'b0;
			blk_b <= 1'b0;
		end else begin
			if ((fsel == FR_BLOCK && tick && rise_a && state == ST_OTA) ||
				(fsel == FR_LEVEL && fault_in.a))
				blk_a <= 1'b1;
			else if (state != ST_OTA)
				blk_a <= 1'b0;
			if ((fsel == FR_BLOCK && tick && rise_b && state == ST_OTB) ||
				(fsel == FR_LEVEL && fault_in.b))
				blk_b <= 1'b1;
			else if (state != ST_OTB)
				blk_b <= 1'b0;
		end
	end

	// In modes 1 to 7 and 10 faults cut the pin at once rather than waiting for a tick
	always_comb begin
		kill_a = 1'b0;
		kill_b = 1'b0;
		case (fsel)
			FR_WAIT, FR_OTHER, FR_RUN, FR_LEVEL: begin
				kill_a = fault_in.a;
				kill_b = fault_in.b;
			end
			FR_OFF, FR_DEAD, FR_WAITB, FR_HALT: begin
				kill_a = any_f;
				kill_b = any_f;
			end
			default: begin
				kill_a = 1'b0;
				kill_b = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			waveform_out_a <= 1'b0;
			waveform_out_b <= 1'b0;
		end else begin
			waveform_out_a <= ctrl.enable && state == ST_OTA &&
				!kill_a && !blk_a;
			waveform_out_b <= ctrl.enable && state == ST_OTB &&
				!kill_b && !blk_b;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	chk_mode4_off:
	assert property (fsel == FR_OFF && any_f |=>
		!waveform_out_a && !waveform_out_b)
		else $error("mode 4 left an output on");
	chk_mode1_wait:
	assert property (tick && fsel == FR_WAIT && fault_in.a &&
		state inside {ST_DTA, ST_OTA} |=> state == ST_WAIT && resume == ST_DTB)
		else $error("mode 1 did not wait");
	chk_mode7_halt:
	assert property (tick && fsel == FR_HALT && any_f |=> state == ST_HALT)
		else $error("mode 7 did not halt");
	chk_halt_exit:
	assert property (state == ST_HALT && tick && restart_req && !any_f &&
		fsel == FR_HALT |=> state == ST_DTA)
		else $error("restart did not resume at dead-time A");
	chk_mode8_jump:
	assert property (tick && fsel == FR_EDGE && rise_a && state == ST_OTA
		|=> state == ST_DTB)
		else $error("mode 8 edge did not jump");
	chk_mode9_blank:
	assert property (tick && fsel == FR_BLOCK && rise_a && state == ST_OTA
		|=> blk_a ##1 !waveform_out_a)
		else $error("mode 9 did not blank");
	chk_dual_none:
	assert property (tick && load && wg == WG_DUAL && fsel == FR_NONE
		|=> cnt == ((len_q[pidx(state)] == '0) ? '0 :
		{1'b0, len_q[pidx(state)]} - 1'b1))
		else $error("dither in dual slope");
	chk_dither_comp:
	assert property (tick && ctrl.enable && load && next_state == ST_OTB &&
		wg == WG_ONE && dither_placement_select == DS_DT_B && cyc_hit &&
		len_q[3] > 12'h001 |=> cnt == (LEN_W+1)'(len_q[3]) - 2)
		else $error("dead-time B dither not paid back");
endmodule : pwm_fault_dither

/* verilog/pwm_fault_pkg.sv */
package pwm_fault_pkg;
	// ==========================================================
	// Widths and defaults
	localparam int LEN_W        = 12;
	localparam int DITHER_W_DEF = 16;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DITHER = 8'h04;
	localparam logic [7:0] OFS_DINC   = 8'h08;
	localparam logic [7:0] OFS_LEN0   = 8'h0c;
	localparam logic [7:0] OFS_CMD    = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// ==========================================================
	// Field positions
	localparam int CTRL_W      = 11;
	localparam int CMD_RESTART = 0;
	localparam int ST_OUT_A    = 6;
	localparam int ST_OUT_B    = 7;
	localparam int ST_PEND     = 8;

	// ==========================================================
	// Reset values
	localparam logic [LEN_W-1:0] LEN_RST = 12'h010;
	localparam logic [1:0]       DSEL_RST = 2'h0;

	// ==========================================================
	// Waveform generation, fault response, dither placement
	localparam logic [1:0] WG_ONE  = 2'h0;
	localparam logic [1:0] WG_TWO  = 2'h1;
	localparam logic [1:0] WG_FOUR = 2'h2;
	localparam logic [1:0] WG_DUAL = 2'h3;

	localparam logic [3:0] FR_NONE   = 4'h0;
	localparam logic [3:0] FR_WAIT   = 4'h1;
	localparam logic [3:0] FR_OTHER  = 4'h2;
	localparam logic [3:0] FR_RUN    = 4'h3;
	localparam logic [3:0] FR_OFF    = 4'h4;
	localparam logic [3:0] FR_DEAD   = 4'h5;
	localparam logic [3:0] FR_WAITB  = 4'h6;
	localparam logic [3:0] FR_HALT   = 4'h7;
	localparam logic [3:0] FR_EDGE   = 4'h8;
	localparam logic [3:0] FR_BLOCK  = 4'h9;
	localparam logic [3:0] FR_LEVEL  = 4'ha;

	localparam logic [1:0] DS_ON_B   = 2'h0;
	localparam logic [1:0] DS_ON_AB  = 2'h1;
	localparam logic [1:0] DS_DT_B   = 2'h2;
	localparam logic [1:0] DS_DT_AB  = 2'h3;

	// ==========================================================
	// Types
	typedef enum logic [5:0] {
		ST_DTA  = 6'h01,
		ST_OTA  = 6'h02,
		ST_DTB  = 6'h04,
		ST_OTB  = 6'h08,
		ST_WAIT = 6'h10,
		ST_HALT = 6'h20
	} phase_t;

	typedef struct packed {
		logic [3:0] presc;
		logic [3:0] fsel;
		logic [1:0] waveform_generation_select;
		logic       enable;
	} ctrl_t;

	typedef struct packed {
		logic a;
		logic b;
	} fault_t;
endpackage : pwm_fault_pkg
